/* dv/eep_mst_bfm.sv */
`timescale 1ns/100ps
module eep_mst_bfm (
    // serial bus toward the slave
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda
);
    // bus idles with both lines high, clock standing still
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // one bit: data moves only while the clock is low
    // a 3 ns lead keeps link edges off the system clock edges
    task automatic bit_xfer(input logic b, output logic r);
        #3 scl = 1'b0;
        #40 sda_rel = b;
        #40 scl = 1'b1;
        #40 r = sda;
        #37;
    endtask

    // start, also usable as repeated start
    task automatic start();
        #3 scl = 1'b0;
        #40 sda_rel = 1'b1;
        #40 scl = 1'b1;
        #60 sda_rel = 1'b0;
        #57;
    endtask

    // stop leaves the bus idle
    task automatic stop();
        #3 scl = 1'b0;
        #40 sda_rel = 1'b0;
        #40 scl = 1'b1;
        #60 sda_rel = 1'b1;
        #57;
    endtask

    // byte out msb first, then release for the slave's ack
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, ack);
    endtask

    // byte in with line released, then our ack or withheld ack
    task automatic get_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(nack, r);
    endtask
endmodule

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
    localparam logic [6:0] DEV_ID = 7'h35; // value is arbitrary
    logic mclk, reset_n, mode, sda_o, sda_oe_n, prog_busy, m_scl, m_rel;
    wire  sda_w = m_rel & (sda_oe_n | sda_o);
    int   fails, checks_done, cycles;

    // single memory on the bus, pull-up resolves the wire
    eep_slave #(.PROG_CYCLES(400), .DEV_ID(DEV_ID)) dut (
        .mclk(mclk), .reset_n(reset_n), .scl(m_scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .mode(mode),
        .prog_busy(prog_busy));
    eep_mst_bfm m (.scl(m_scl), .sda_rel(m_rel), .sda(sda_w));

    // system clock and hang guard
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // start plus select byte, ack expected or not
    task automatic sel(input logic rnw, input logic exp_nack);
        logic a;
        m.start();
        m.put_byte({DEV_ID, rnw}, a);
        chk("select ack", {7'h00, exp_nack}, {7'h00, a});
    endtask

    task automatic wr_seq(input logic [7:0] addr, input logic [7:0] dq[$]);
        logic a;
        sel(1'b0, 1'b0);
        m.put_byte(addr, a);
        chk("address ack", 8'h00, {7'h00, a});
        foreach (dq[i]) begin
            m.put_byte(dq[i], a);
            chk("data ack", 8'h00, {7'h00, a});
        end
        m.stop();
        repeat (10) @(negedge mclk);
        chk("busy after stop", 8'h01, {7'h00, prog_busy});
    endtask

    task automatic wait_prog();
        int n;
        n = 0;
        while (prog_busy !== 1'b0 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        chk("programming done", 8'h00, {7'h00, prog_busy});
    endtask

    // dummy write of the address, repeated start, sequential read
    task automatic rd_seq(input logic [7:0] addr, input logic [7:0] eq[$]);
        logic a;
        logic [7:0] d;
        sel(1'b0, 1'b0);
        m.put_byte(addr, a);
        chk("read address ack", 8'h00, {7'h00, a});
        sel(1'b1, 1'b0);
        foreach (eq[i]) begin
            m.get_byte(i == eq.size() - 1, d);
            chk("read data", eq[i], d);
        end
        m.stop();
    endtask

    task automatic t_reset();
        reset_n <= 1'b0;
        sel(1'b0, 1'b1);
        m.stop();
        @(posedge mclk);
        reset_n <= 1'b1;
        repeat (5) @(posedge mclk);
    endtask

    task automatic t_write_poll();
        logic [7:0] d;
        wr_seq(8'h40, '{8'h5A});
        sel(1'b0, 1'b1);
        m.stop();
        wait_prog();
        sel(1'b0, 1'b0);
        m.stop();
        rd_seq(8'h40, '{8'h5A});
        sel(1'b1, 1'b0);
        m.get_byte(1'b1, d);
        chk("current address read", 8'hFF, d);
        m.stop();
        rd_seq(8'h40, '{8'h5A, 8'hFF, 8'hFF});
    endtask

    task automatic t_mismatch();
        logic a;
        m.start();
        m.put_byte({DEV_ID ^ 7'h01, 1'b0}, a);
        chk("foreign select", 8'h01, {7'h00, a});
        m.put_byte(8'h00, a);
        chk("after mismatch", 8'h01, {7'h00, a});
        m.stop();
        m.put_byte({DEV_ID, 1'b0}, a);
        chk("no start", 8'h01, {7'h00, a});
        m.stop();
    endtask

    task automatic t_page();
        @(posedge mclk);
        mode <= 1'b0;
        repeat (5) @(posedge mclk);
        wr_seq(8'h1E, '{8'h11, 8'h22, 8'h33});
        wait_prog();
        rd_seq(8'h18, '{8'h33});
        rd_seq(8'h1E, '{8'h11, 8'h22});
    endtask

    task automatic t_multi();
        @(posedge mclk);
        mode <= 1'b1; // pull-up level of an open strap
        repeat (5) @(posedge mclk);
        wr_seq(8'h2E, '{8'h44, 8'h55, 8'h66});
        // bytes across two rows double the programming time
        repeat (450) @(negedge mclk);
        chk("row span busy", 8'h01, {7'h00, prog_busy});
        wait_prog();
        rd_seq(8'h2E, '{8'h44, 8'h55, 8'h66});
        rd_seq(8'h28, '{8'hFF});
    endtask

    // reset, then the scenarios in turn
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        mode = 1'b1;
        fails = 0;
        checks_done = 0;
        cycles = 0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (5) @(posedge mclk);
        t_reset();
        t_write_poll();
        t_mismatch();
        t_page();
        t_multi();
        finish_test();
    end
endmodule

/* rtl/eep_link_if.sv */
`timescale 1ns/100ps
interface eep_link_if;
    logic [7:0] word;
    logic       tog;

    // serial-clock side produces, system side consumes
    modport link (output word, output tog);
    modport core (input word, input tog);
endinterface

/* rtl/eep_pkg.sv */
package eep_pkg;

    // clock and self-timed programming
    localparam int CLK_HZ       = 100_000_000;
    localparam int PROG_TIME_MS = 10;
    localparam int PROG_CYCLES  = PROG_TIME_MS * (CLK_HZ / 1000);

    // storage and byte framing
    localparam int         MEM_DEPTH = 256;
    localparam int         WR_DEPTH  = 8;
    localparam logic [3:0] WR_FULL   = 4'h8;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] BIT_ACK   = 4'h8;
    localparam logic [7:0] MEM_RST   = 8'hFF;
    localparam logic [7:0] ADDR_STEP = 8'h01;
    localparam logic [2:0] ROW_STEP  = 3'h1;

    // select identifier; this value is arbitrary
    localparam logic [6:0] DEV_ID_DFLT = 7'h2B;

    // protocol phase of the slave
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADDR,
        ST_WDATA,
        ST_RDATA
    } eep_state_t;

endpackage

/* rtl/eep_scl_rx.sv */
`timescale 1ns/100ps
module eep_scl_rx (
    // serial clock domain
    input  wire logic       scl,
    input  wire logic       reset_n,
    input  wire logic       sda_i,
    // word and event toward the system clock
    eep_link_if.link        lnk
);

    typedef struct packed {
        logic [7:0] word;
        logic       tog;
    } eep_rx_t;

    eep_rx_t q;
    eep_rx_t d;

    // shift in data and flip the event toggle on every rising edge
    always_comb begin
        d      = q;
        d.word = {q.word[6:0], sda_i};
        d.tog  = ~q.tog;
    end

    always_ff @(posedge scl or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // word stays put for a whole clock period after the toggle moves
    assign lnk.word = q.word;
    assign lnk.tog  = q.tog;

endmodule

/* rtl/eep_slave.sv */
`timescale 1ns/100ps
// Behaviour
// - data falling while clock high is a start.
// - data rising while clock high is a stop, ending the transfer.
// - every command needs a start; traffic without one is ignored.
// - stop after a read returns to standby.
// - stop after a write launches the self-timed programming cycle.
// - transmitter releases data after 8 bits; receiver pulls low on 9th.
// - received bits are sampled on serial clock rising edges.
// - eighth select bit one means read, zero means write.
// - matching identifier is acknowledged low during the 9th bit.
// - device acks each written byte; master acks each read byte but the last.
// - write-style pin high means multibyte, low means page write.
// - an unconnected write-style pin reads high, giving multibyte.
// - during power-on reset nothing responds.
// - only the master starts transfers and supplies the clock.
// - storage is 256 bytes of eight bits.
// - after a write select, an 8-bit byte address is taken and acked.
// - page write wraps the low three address bits within a row.
// - select bytes go unacknowledged while programming runs.
// - the address counter steps after every byte read out.
module eep_slave #(
    parameter int         PROG_CYCLES = eep_pkg::PROG_CYCLES,
    parameter logic [6:0] DEV_ID      = eep_pkg::DEV_ID_DFLT
) (
    // system clock and power-on reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // two-wire bus
    input  wire logic scl,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_n,
    // write-style strap and status
    input  wire logic mode,
    output logic      prog_busy
);

    localparam int TIMER_W = $clog2(2 * PROG_CYCLES);

    typedef struct packed {
        logic                   scl_m1;
        logic                   scl_m2;
        logic                   scl_m3;
        logic                   sda_m1;
        logic                   sda_m2;
        logic                   sda_m3;
        logic                   tog_m1;
        logic                   tog_m2;
        logic                   tog_m3;
        logic                   mode_m1;
        logic                   mode_m2;
        eep_pkg::eep_state_t    state;
        logic [3:0]             bitcnt;
        logic                   ack;
        logic                   rnw;
        logic [7:0]             rbyte;
        logic [7:0]             addr;
        logic                   mode_multi;
        logic [3:0]             wr_cnt;
        logic [2:0]             wr_ptr;
        logic [7:0][7:0]        wr_addr;
        logic [7:0][7:0]        wr_data;
        logic                   span;
        logic                   busy;
        logic [TIMER_W-1:0]     timer;
        logic                   sda_oe_n;
        logic                   sda_o;
        logic [eep_pkg::MEM_DEPTH-1:0][7:0] mem;
    } eep_core_t;

    eep_core_t  q;
    eep_core_t  d;
    eep_link_if lnk ();
    logic       start_ev;
    logic       stop_ev;
    logic       fall_ev;
    logic       bit_ev;

    // serial-clock receiver
    eep_scl_rx u_rx (
        .scl     (scl),
        .reset_n (reset_n),
        .sda_i   (sda_i),
        .lnk     (lnk.link)
    );

    // bus conditions seen through the synchronisers
    assign start_ev = q.scl_m2 && q.scl_m3 && q.sda_m3 && !q.sda_m2;
    assign stop_ev  = q.scl_m2 && q.scl_m3 && !q.sda_m3 && q.sda_m2;
    assign fall_ev  = q.scl_m3 && !q.scl_m2;
    assign bit_ev   = q.tog_m2 ^ q.tog_m3;

    // next state of the whole slave
    always_comb begin
        d         = q;
        d.scl_m1  = scl;
        d.scl_m2  = q.scl_m1;
        d.scl_m3  = q.scl_m2;
        d.sda_m1  = sda_i;
        d.sda_m2  = q.sda_m1;
        d.sda_m3  = q.sda_m2;
        d.tog_m1  = lnk.tog;
        d.tog_m2  = q.tog_m1;
        d.tog_m3  = q.tog_m2;
        d.mode_m1 = mode;
        d.mode_m2 = q.mode_m1;
        d.sda_o   = 1'b0;  // open drain: only ever pulls low

        // programming timer, latches copied to the array at the end
        if (q.busy) begin
            if (q.timer == '0) begin
                for (int i = 0; i < eep_pkg::WR_DEPTH; i++) begin
                    if (4'(i) < q.wr_cnt) begin
                        d.mem[q.wr_addr[i]] = q.wr_data[i];
                    end
                end
                d.busy   = 1'b0;
                d.wr_cnt = '0;
                d.wr_ptr = '0;
                d.span   = 1'b0;
            end else begin
                d.timer = q.timer - 1'b1;
            end
        end

        // one received bit per rising serial clock, ignored when idle
        if (bit_ev && q.state != eep_pkg::ST_IDLE) begin
            if (q.bitcnt != eep_pkg::BIT_ACK) begin
                d.bitcnt = q.bitcnt + 1'b1;
                if (q.bitcnt == eep_pkg::BIT_LAST) begin
                    unique case (q.state)
                        eep_pkg::ST_DEV: begin
                            d.rnw = lnk.word[0];
                            // no ack on mismatch or while programming
                            d.ack = (lnk.word[7:1] == DEV_ID)
                                    && !q.busy;
                            if (!lnk.word[0]) begin
                                // pull-up makes a floating pin read high
                                d.mode_multi = q.mode_m2;
                            end
                        end
                        eep_pkg::ST_ADDR: begin
                            d.addr = lnk.word;
                            d.ack  = 1'b1;
                        end
                        eep_pkg::ST_WDATA: begin
                            d.wr_addr[q.wr_ptr] = q.addr;
                            d.wr_data[q.wr_ptr] = lnk.word;
                            d.wr_ptr            = q.wr_ptr + 1'b1;
                            if (q.wr_cnt != eep_pkg::WR_FULL) begin
                                d.wr_cnt = q.wr_cnt + 1'b1;
                            end
                            if (q.wr_cnt != '0 &&
                                q.addr[7:3] != q.wr_addr[0][7:3]) begin
                                d.span = 1'b1;
                            end
                            if (q.mode_multi) begin
                                d.addr = q.addr + eep_pkg::ADDR_STEP;
                            end else begin
                                d.addr = {q.addr[7:3],
                                          q.addr[2:0] + eep_pkg::ROW_STEP};
                            end
                            d.ack = 1'b1;
                        end
                        eep_pkg::ST_RDATA: begin
                            d.ack = 1'b0;
                        end
                        eep_pkg::ST_IDLE: begin
                            d.ack = 1'b0;
                        end
                    endcase
                end
            end else begin
                // ninth bit: acknowledge slot
                d.bitcnt = '0;
                d.ack    = 1'b0;
                unique case (q.state)
                    eep_pkg::ST_DEV: begin
                        if (!q.ack) begin
                            d.state = eep_pkg::ST_IDLE;
                        end else if (q.rnw) begin
                            d.rbyte = q.mem[q.addr];
                            d.addr  = q.addr + eep_pkg::ADDR_STEP;
                            d.state = eep_pkg::ST_RDATA;
                        end else begin
                            d.state = eep_pkg::ST_ADDR;
                        end
                    end
                    eep_pkg::ST_ADDR: begin
                        d.state = eep_pkg::ST_WDATA;
                    end
                    eep_pkg::ST_WDATA: begin
                        d.state = eep_pkg::ST_WDATA;
                    end
                    eep_pkg::ST_RDATA: begin
                        // low means the master acked the byte
                        if (!lnk.word[0]) begin
                            d.rbyte = q.mem[q.addr];
                            d.addr  = q.addr + eep_pkg::ADDR_STEP;
                        end else begin
                            d.state = eep_pkg::ST_IDLE;
                        end
                    end
                    eep_pkg::ST_IDLE: begin
                        d.state = eep_pkg::ST_IDLE;
                    end
                endcase
            end
        end

        // drive or release data while the serial clock is low
        if (fall_ev) begin
            if (q.state == eep_pkg::ST_RDATA &&
                q.bitcnt != eep_pkg::BIT_ACK) begin
                d.sda_oe_n = q.rbyte[~q.bitcnt[2:0]];
            end else begin
                d.sda_oe_n = !(q.bitcnt == eep_pkg::BIT_ACK
                               && q.ack);
            end
        end

        // start reframes the bus, committed latches are kept
        if (start_ev) begin
            d.state    = eep_pkg::ST_DEV;
            d.bitcnt   = '0;
            d.ack      = 1'b0;
            d.sda_oe_n = 1'b1;
            if (!q.busy) begin
                d.wr_cnt = '0;
                d.wr_ptr = '0;
                d.span   = 1'b0;
            end
        end

        // stop ends the transfer, writes launch programming
        if (stop_ev) begin
            d.state    = eep_pkg::ST_IDLE;
            d.bitcnt   = '0;
            d.ack      = 1'b0;
            d.sda_oe_n = 1'b1;
            if (q.state == eep_pkg::ST_WDATA && q.wr_cnt != '0
                && !q.busy) begin
                d.busy  = 1'b1;
                d.timer = q.span ? TIMER_W'(2 * PROG_CYCLES - 1)
                                 : TIMER_W'(PROG_CYCLES - 1);
            end
        end
    end

    // power-on reset holds everything quiet, array erased to ones
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{state: eep_pkg::ST_IDLE,
                   sda_oe_n: 1'b1,
                   mode_multi: 1'b1,
                   mem: {eep_pkg::MEM_DEPTH{eep_pkg::MEM_RST}},
                   default: '0};
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign sda_o     = q.sda_o;
    assign sda_oe_n  = q.sda_oe_n;
    assign prog_busy = q.busy;

    // bus condition, acknowledge, bit count and address checks
    a_start_seen: assert property (
        @(posedge mclk) disable iff (!reset_n)
        start_ev |=> q.state == eep_pkg::ST_DEV && q.bitcnt == 4'h0)
        else $error("start not framed");

    a_stop_idle: assert property (
        @(posedge mclk) disable iff (!reset_n)
        stop_ev |=> q.state == eep_pkg::ST_IDLE && q.sda_oe_n)
        else $error("stop did not return to idle");

    a_stop_prog: assert property (
        @(posedge mclk) disable iff (!reset_n)
        stop_ev && q.state == eep_pkg::ST_WDATA && q.wr_cnt != 4'h0
        && !q.busy |=> q.busy [*3])
        else $error("write stop did not start programming");

    a_idle_release: assert property (
        @(posedge mclk) disable iff (!reset_n)
        q.state == eep_pkg::ST_IDLE |-> q.sda_oe_n)
        else $error("data driven while idle");

    a_ack_drive: assert property (
        @(posedge mclk) disable iff (!reset_n)
        fall_ev && q.bitcnt == 4'h8 && q.ack |=> !q.sda_oe_n)
        else $error("acknowledge not driven");

    a_busy_noack: assert property (
        @(posedge mclk) disable iff (!reset_n)
        q.busy && bit_ev && q.state == eep_pkg::ST_DEV
        && q.bitcnt == 4'h7 |=> !q.ack)
        else $error("select acked while programming");

    a_bit_count: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bit_ev && q.state != eep_pkg::ST_IDLE && q.bitcnt < 4'h8
        && !start_ev && !stop_ev |=> q.bitcnt == $past(q.bitcnt) + 4'h1)
        else $error("bit count did not advance");

    a_page_wrap: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bit_ev && q.state == eep_pkg::ST_WDATA && q.bitcnt == 4'h7
        && !q.mode_multi && !start_ev && !stop_ev
        |=> q.addr[7:3] == $past(q.addr[7:3])
        && q.addr[2:0] == $past(q.addr[2:0]) + 3'h1)
        else $error("page address left its row");

    a_read_incr: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bit_ev && q.state == eep_pkg::ST_RDATA && q.bitcnt == 4'h8
        && !lnk.word[0] && !start_ev && !stop_ev
        |=> q.addr == $past(q.addr) + 8'h01)
        else $error("read address did not step");

endmodule
